/* File: core/eq_ctl_params.svh */
// constants of the serial-mode control logic of the dual-channel equalizer
// Summary of operation
// RULE_01: serial control mode while mode select high
// RULE_02: chip select low disables the serial interface
// RULE_03: seven-bit address, upper four bits fixed 0101
// RULE_04: straps pulled up; low strap inverts address bit
// RULE_05: reset input high resets all digital logic
// RULE_06: channel A off input high disables output
// RULE_07: channel B off input high disables output
// RULE_08: channel A loss flag high below threshold
// RULE_09: channel B loss flag high below threshold
// RULE_10: data line open drain, device only pulls low
// RULE_11: serial clock is input only from controller
// RULE_12: internal squelch enabled by serially written setting
// RULE_13: standard framing, start, stop, acknowledge, target only
`ifndef EQ_CTL_PARAMS_SVH
`define EQ_CTL_PARAMS_SVH

// fixed upper address bits
`define ADDR_FIXED_HI   4'h5
// register map reached over the serial interface
`define REG_CTRL        2'h0
`define REG_STAT        2'h1
`define REG_COUNT       4
`define REG_RESET       8'h00
// control register fields
`define CTRL_SQUELCH_A  0
`define CTRL_SQUELCH_B  1
// bits per byte on the wire
`define BITS_PER_BYTE   4'h8

// positions of the pins in the synchroniser vector
`define PIN_SCL         0
`define PIN_SDA         1
`define PIN_CS          2
`define PIN_MODE        3
`define PIN_OFF_A       4
`define PIN_OFF_B       5
`define PIN_BELOW_A     6
`define PIN_BELOW_B     7
`define PIN_STRAP_0     8
`define PIN_STRAP_1     9
`define PIN_STRAP_2     10
`define PIN_COUNT       11

`endif

/* File: core/eq_ctl_pkg.sv */
// types shared by the serial-mode control logic
package eq_ctl_pkg;
`include "eq_ctl_params.svh"

   // serial target protocol states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_ADDR,
      ST_ACK_ADDR,
      ST_WRITE,
      ST_WACK,
      ST_READ,
      ST_RACK,
      ST_IGNORE
   } bus_state_t;

   // two-stage synchroniser state
   typedef struct packed {
      logic [`PIN_COUNT-1:0] meta;
      logic [`PIN_COUNT-1:0] sync;
   } sync_state_t;

   // whole state of the control block
   typedef struct packed {
      bus_state_t      state;
      logic            scl_prev;
      logic            sda_prev;
      logic [7:0]      shift;
      logic [7:0]      tx;
      logic [3:0]      bitcnt;
      logic            rd;
      logic            ptr_loaded;
      logic [1:0]      ptr;
      logic [3:0][7:0] regs;
      logic            sda_oe;
      logic            out_en_a;
      logic            out_en_b;
      logic            los_oe_a;
      logic            los_oe_b;
   } ctl_state_t;

endpackage

/* File: core/eq_pin_sync.sv */
// two flip-flop synchroniser for all asynchronous pins of the control block
`timescale 1ns/1ps
`default_nettype none
`include "eq_ctl_params.svh"
module eq_pin_sync
   import eq_ctl_pkg::*;
(
   // clock and reset
   input  wire logic                  clk,
   input  wire logic                  rst,
   // raw pins and their synchronised copies
   input  wire logic [`PIN_COUNT-1:0] pins,
   output logic      [`PIN_COUNT-1:0] pins_sync
);

   sync_state_t st;       // registered state
   sync_state_t next_st;  // next value

   // first stage feeds only the second stage
   always_comb begin
      next_st      = st;
      next_st.meta = pins;
      next_st.sync = st.meta;
   end

   // reset to zero; callers must tolerate two cycles of zero after release
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign pins_sync = st.sync;

endmodule
`default_nettype wire

/* File: core/eq_serial_ctl.sv */
// serial-mode control logic: two-wire target, squelch, output and loss pins
`timescale 1ns/1ps
`default_nettype none
`include "eq_ctl_params.svh"
module eq_serial_ctl
   import eq_ctl_pkg::*;
(
   // clock and reset
   input  wire logic MCLK,
   input  wire logic RST,
   // mode and interface select pins
   input  wire logic MODE_SEL,
   input  wire logic CHIP_SEL,
   // two-wire serial interface
   input  wire logic SCL,
   input  wire logic SDA_I,
   output logic      SDA_O,
   output logic      SDA_OE,
   // address straps
   input  wire logic ADDR_STRAP_2,
   input  wire logic ADDR_STRAP_1,
   input  wire logic ADDR_STRAP_0,
   // output stage disable pins
   input  wire logic CHAN_A_OUTPUT_OFF,
   input  wire logic CHAN_B_OUTPUT_OFF,
   // analog amplitude detector results
   input  wire logic CHAN_A_BELOW_THRESH,
   input  wire logic CHAN_B_BELOW_THRESH,
   // output stage enables toward the analog path
   output logic      CHAN_A_OUT_ENABLE,
   output logic      CHAN_B_OUT_ENABLE,
   // open-drain loss-of-signal pins
   output logic      CHAN_A_SIGNAL_LOST_O,
   output logic      CHAN_A_SIGNAL_LOST_OE,
   output logic      CHAN_B_SIGNAL_LOST_O,
   output logic      CHAN_B_SIGNAL_LOST_OE
);

   // target address from the straps: bit 2 follows, bits 1 and 0 invert
   function automatic logic [6:0] dev_addr(input logic [2:0] strap);
      dev_addr = {`ADDR_FIXED_HI, strap[2], ~strap[1], ~strap[0]}; // [RULE_03] [RULE_04]
   endfunction

   // read data: status register shows live pin state, others read back
   function automatic logic [7:0] read_byte(input logic [3:0][7:0] regs,
                                            input logic [1:0]      idx,
                                            input logic [3:0]      live);
      if (idx == `REG_STAT) begin
         read_byte = {4'h0, live};
      end else begin
         read_byte = regs[idx];
      end
   endfunction

   logic [`PIN_COUNT-1:0] pin_raw;   // raw asynchronous pins
   logic [`PIN_COUNT-1:0] pin_s;     // synchronised pins
   ctl_state_t            st;        // registered state
   ctl_state_t            next_st;   // next value
   logic                  scl;       // synced clock line
   logic                  sda;       // synced data line
   logic                  serial_on; // interface enabled
   logic                  scl_rise;  // clock line rose
   logic                  scl_fall;  // clock line fell
   logic                  start_c;   // start condition seen
   logic                  stop_c;    // stop condition seen
   logic [2:0]            strap;     // synced straps
   logic [3:0]            live;      // live status bits

   // every pin crosses into the clock domain before use
   assign pin_raw = {ADDR_STRAP_2, ADDR_STRAP_1, ADDR_STRAP_0,
                     CHAN_B_BELOW_THRESH, CHAN_A_BELOW_THRESH,
                     CHAN_B_OUTPUT_OFF, CHAN_A_OUTPUT_OFF,
                     MODE_SEL, CHIP_SEL, SDA_I, SCL};

   eq_pin_sync u_sync (
      .clk       (MCLK),
      .rst       (RST),
      .pins      (pin_raw),
      .pins_sync (pin_s)
   );

   // the clock line is only ever sampled, never driven
   assign scl       = pin_s[`PIN_SCL]; // [RULE_11]
   assign sda       = pin_s[`PIN_SDA];
   assign strap     = {pin_s[`PIN_STRAP_2], pin_s[`PIN_STRAP_1], pin_s[`PIN_STRAP_0]};
   assign live      = {pin_s[`PIN_BELOW_B], pin_s[`PIN_BELOW_A],
                       pin_s[`PIN_OFF_B], pin_s[`PIN_OFF_A]};
   // serial mode needs mode select high and chip select high
   assign serial_on = pin_s[`PIN_MODE] & pin_s[`PIN_CS]; // [RULE_01] [RULE_02]
   // edges and bus conditions from the previous sample
   assign scl_rise  = scl & ~st.scl_prev;
   assign scl_fall  = ~scl & st.scl_prev;
   assign start_c   = scl & st.scl_prev & st.sda_prev & ~sda; // [RULE_13]
   assign stop_c    = scl & st.scl_prev & ~st.sda_prev & sda; // [RULE_13]

   // next-state logic of the whole block
   always_comb begin
      logic [7:0] rdata;
      rdata          = read_byte(st.regs, st.ptr, live);
      next_st        = st;
      next_st.scl_prev = scl;
      next_st.sda_prev = sda;
      // output stage off by pin, or by squelch when the signal is lost
      next_st.out_en_a = ~(pin_s[`PIN_OFF_A] |
                           (st.regs[`REG_CTRL][`CTRL_SQUELCH_A] & pin_s[`PIN_BELOW_A])); // [RULE_06] [RULE_12]
      next_st.out_en_b = ~(pin_s[`PIN_OFF_B] |
                           (st.regs[`REG_CTRL][`CTRL_SQUELCH_B] & pin_s[`PIN_BELOW_B])); // [RULE_07] [RULE_12]
      // loss pin released (pulled high) when below, pulled low otherwise
      next_st.los_oe_a = ~pin_s[`PIN_BELOW_A]; // [RULE_08]
      next_st.los_oe_b = ~pin_s[`PIN_BELOW_B]; // [RULE_09]
      if (!serial_on) begin
         // interface off: release the data line and forget the transfer
         next_st.state  = ST_IDLE; // [RULE_01] [RULE_02]
         next_st.sda_oe = 1'b0;
      end else if (start_c) begin
         // start or repeated start: always look for our address
         next_st.state  = ST_ADDR; // [RULE_13]
         next_st.bitcnt = 4'h0;
         next_st.sda_oe = 1'b0;
      end else if (stop_c) begin
         next_st.state  = ST_IDLE; // [RULE_13]
         next_st.sda_oe = 1'b0;
      end else if (scl_rise) begin
         // data is sampled while the clock line is high
         case (st.state)
            ST_ADDR, ST_WRITE: begin
               if (st.bitcnt != `BITS_PER_BYTE) begin
                  next_st.shift  = {st.shift[6:0], sda};
                  next_st.bitcnt = st.bitcnt + 4'h1;
               end
            end
            ST_RACK: begin
               // a not-acknowledge ends the read until the next start
               if (sda) begin
                  next_st.state = ST_IGNORE; // [RULE_13]
               end
            end
            default: begin
            end
         endcase
      end else if (scl_fall) begin
         // the data line only changes while the clock line is low
         case (st.state)
            ST_ADDR: begin
               if (st.bitcnt == `BITS_PER_BYTE) begin
                  if (st.shift[7:1] == dev_addr(strap)) begin
                     next_st.sda_oe = 1'b1; // [RULE_03]
                     next_st.rd     = st.shift[0];
                     next_st.state  = ST_ACK_ADDR;
                  end else begin
                     next_st.state  = ST_IGNORE;
                  end
               end
            end
            ST_ACK_ADDR: begin
               if (st.rd) begin
                  next_st.tx     = rdata;
                  next_st.ptr    = st.ptr + 2'h1;
                  next_st.sda_oe = ~rdata[7]; // [RULE_10]
                  next_st.bitcnt = 4'h1;
                  next_st.state  = ST_READ;
               end else begin
                  next_st.sda_oe     = 1'b0;
                  next_st.bitcnt     = 4'h0;
                  next_st.ptr_loaded = 1'b0;
                  next_st.state      = ST_WRITE;
               end
            end
            ST_WRITE: begin
               if (st.bitcnt == `BITS_PER_BYTE) begin
                  next_st.sda_oe = 1'b1;
                  next_st.state  = ST_WACK;
                  if (!st.ptr_loaded) begin
                     // first byte selects the register, upper bits ignored
                     next_st.ptr        = st.shift[1:0];
                     next_st.ptr_loaded = 1'b1;
                  end else begin
                     // status is read-only; a write to it only moves on
                     if (st.ptr != `REG_STAT) begin
                        next_st.regs[st.ptr] = st.shift; // [RULE_12]
                     end
                     next_st.ptr = st.ptr + 2'h1;
                  end
               end
            end
            ST_WACK: begin
               next_st.sda_oe = 1'b0;
               next_st.bitcnt = 4'h0;
               next_st.state  = ST_WRITE;
            end
            ST_READ: begin
               if (st.bitcnt == `BITS_PER_BYTE) begin
                  next_st.sda_oe = 1'b0;
                  next_st.state  = ST_RACK;
               end else begin
                  next_st.tx     = {st.tx[6:0], 1'b0};
                  next_st.sda_oe = ~st.tx[6]; // [RULE_10]
                  next_st.bitcnt = st.bitcnt + 4'h1;
               end
            end
            ST_RACK: begin
               // acknowledged: next byte, pointer wraps round the map
               next_st.tx     = rdata;
               next_st.ptr    = st.ptr + 2'h1;
               next_st.sda_oe = ~rdata[7];
               next_st.bitcnt = 4'h1;
               next_st.state  = ST_READ;
            end
            default: begin
            end
         endcase
      end
   end

   // one register for all state; reset clears every field except the output and loss enables, which it sets high
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         st          <= '0; // [RULE_05]
         st.out_en_a <= 1'b1;
         st.out_en_b <= 1'b1;
         st.los_oe_a <= 1'b1;
         st.los_oe_b <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // open-drain pins only ever drive low
   assign SDA_O                 = 1'b0; // [RULE_10]
   assign SDA_OE                = st.sda_oe;
   assign CHAN_A_OUT_ENABLE     = st.out_en_a;
   assign CHAN_B_OUT_ENABLE     = st.out_en_b;
   assign CHAN_A_SIGNAL_LOST_O  = 1'b0;
   assign CHAN_A_SIGNAL_LOST_OE = st.los_oe_a;
   assign CHAN_B_SIGNAL_LOST_O  = 1'b0;
   assign CHAN_B_SIGNAL_LOST_OE = st.los_oe_b;

   // checks of the control behaviour
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (RST);

   sequence s_addr_match;
      st.state == ST_ADDR && scl_fall && st.bitcnt == `BITS_PER_BYTE
         && st.shift[7:1] == dev_addr(strap) && serial_on && !start_c && !stop_c;
   endsequence

   sequence s_ack_held;
      SDA_OE && st.state == ST_ACK_ADDR;
   endsequence

   property p_mode_off;
      !pin_s[`PIN_MODE] |=> st.state == ST_IDLE && !SDA_OE;
   endproperty
   a_mode_off: assert property (p_mode_off) else $error("serial logic active outside serial mode"); // [RULE_01]

   property p_cs_off;
      !pin_s[`PIN_CS] ##1 !pin_s[`PIN_CS] |=> st.state == ST_IDLE && !SDA_OE;
   endproperty
   a_cs_off: assert property (p_cs_off) else $error("data line driven with chip select low"); // [RULE_02]

   property p_addr_ack;
      s_addr_match |=> s_ack_held;
   endproperty
   a_addr_ack: assert property (p_addr_ack) else $error("own address not acknowledged"); // [RULE_03]

   property p_default_addr;
      st.state == ST_ADDR && scl_fall && st.bitcnt == `BITS_PER_BYTE && strap == 3'h7
         && st.shift == 8'h58 && serial_on && !start_c && !stop_c |=> s_ack_held;
   endproperty
   a_default_addr: assert property (p_default_addr) else $error("default address wrong"); // [RULE_04]

   property p_reset_release;
      $fell(RST) |-> st.state == ST_IDLE && !SDA_OE && CHAN_A_OUT_ENABLE && CHAN_B_OUT_ENABLE;
   endproperty
   a_reset_release: assert property (disable iff (1'b0) p_reset_release) else $error("state not cleared by reset"); // [RULE_05]

   property p_off_a;
      pin_s[`PIN_OFF_A] |=> !CHAN_A_OUT_ENABLE;
   endproperty
   a_off_a: assert property (p_off_a) else $error("channel A output not disabled"); // [RULE_06]

   property p_off_b;
      pin_s[`PIN_OFF_B] |=> !CHAN_B_OUT_ENABLE;
   endproperty
   a_off_b: assert property (p_off_b) else $error("channel B output not disabled"); // [RULE_07]

   property p_los_a;
      ##1 CHAN_A_SIGNAL_LOST_OE == !$past(pin_s[`PIN_BELOW_A]);
   endproperty
   a_los_a: assert property (p_los_a) else $error("channel A loss pin wrong"); // [RULE_08]

   property p_los_b;
      ##1 CHAN_B_SIGNAL_LOST_OE == !$past(pin_s[`PIN_BELOW_B]);
   endproperty
   a_los_b: assert property (p_los_b) else $error("channel B loss pin wrong"); // [RULE_09]

   property p_sda_change;
      $rose(SDA_OE) |-> !scl;
   endproperty
   a_sda_change: assert property (p_sda_change) else $error("data line pulled while clock high"); // [RULE_13]

   property p_squelch;
      st.regs[`REG_CTRL][`CTRL_SQUELCH_A] && pin_s[`PIN_BELOW_A] |=> !CHAN_A_OUT_ENABLE;
   endproperty
   a_squelch: assert property (p_squelch) else $error("squelch did not disable channel A"); // [RULE_12]

   property p_ack_release;
      st.state == ST_WACK && scl_fall && serial_on && !start_c && !stop_c |=> !SDA_OE [*2];
   endproperty
   a_ack_release: assert property (p_ack_release) else $error("data line held after acknowledge"); // [RULE_10]

endmodule
`default_nettype wire

/* File: verification/eq_bus_host.sv */
// two-wire bus controller model that drives the serial clock and data line
`timescale 1ns/1ps
`default_nettype none
module eq_bus_host (
   // bench clock
   input  wire logic clk,
   // resolved data line level
   input  wire logic sda,
   // controller drives
   output logic      scl,
   output logic      sda_low
);
   localparam int HALF = 12; // half bit in clocks, kept above the 8 clock minimum

   // idle: clock high, data released to its pull-up
   initial begin
      scl     = 1'b1;
      sda_low = 1'b0;
   end

   // wait one half bit
   task automatic half();
      repeat (HALF) @(posedge clk);
   endtask

   // start or repeated start: data falls while the clock is high
   task automatic start();
      @(posedge clk);
      sda_low <= 1'b0;
      half();
      scl <= 1'b1; // only the controller ever moves the clock
      half();
      sda_low <= 1'b1;
      half();
      scl <= 1'b0;
      half();
   endtask

   // stop: data rises while the clock is high, clock then stands high
   task automatic stop();
      sda_low <= 1'b1;
      half();
      scl <= 1'b1;
      half();
      sda_low <= 1'b0;
      half();
   endtask

   // eight data bits then the acknowledge slot, msb first; rx holds the wire levels
   task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--) begin
         sda_low <= ~tx[i]; // a one is a release, never a drive high
         half();
         scl <= 1'b1;
         half();
         rx[i] = sda; // data is stable for the whole high phase
         scl <= 1'b0;
      end
   endtask
endmodule
`default_nettype wire

/* File: verification/equalizer_serial_mode_control_test.sv */
// self-checking bench of the serial-mode control logic of the equalizer
`timescale 1ns/1ps
`default_nettype none
`include "eq_ctl_params.svh"
module equalizer_serial_mode_control_test;
   // inputs of the design
   logic       mclk, rst, mode_sel, chip_sel;
   logic [2:0] strap;
   logic       off_a, off_b, below_a, below_b;
   // outputs of the design and the controller
   logic       sda_o, sda_oe, en_a, en_b, lo_a, loe_a, lo_b, loe_b, scl, host_low;
   // resolved open-drain wires, all with pull-ups
   wire logic  sda, lost_a, lost_b;
   // bookkeeping
   int         error_cnt, n_checks, cycles;
   logic [8:0] rx;
   logic [6:0] adr;
   // rows: off a, off b, below a, below b | enable a, enable b, lost a, lost b
   localparam logic [7:0] ROWS [6] = '{8'h0C, 8'h84, 8'h48, 8'h2E, 8'h1D, 8'hF3};
   localparam int LIMIT = 40000; // about twice the expected run

   assign sda    = !((sda_oe && !sda_o) || host_low);
   assign lost_a = !(loe_a && !lo_a);
   assign lost_b = !(loe_b && !lo_b);

   eq_serial_ctl u_dut (.MCLK(mclk), .RST(rst), .MODE_SEL(mode_sel), .CHIP_SEL(chip_sel),
      .SCL(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe), .ADDR_STRAP_2(strap[2]),
      .ADDR_STRAP_1(strap[1]), .ADDR_STRAP_0(strap[0]), .CHAN_A_OUTPUT_OFF(off_a),
      .CHAN_B_OUTPUT_OFF(off_b), .CHAN_A_BELOW_THRESH(below_a), .CHAN_B_BELOW_THRESH(below_b),
      .CHAN_A_OUT_ENABLE(en_a), .CHAN_B_OUT_ENABLE(en_b), .CHAN_A_SIGNAL_LOST_O(lo_a),
      .CHAN_A_SIGNAL_LOST_OE(loe_a), .CHAN_B_SIGNAL_LOST_O(lo_b), .CHAN_B_SIGNAL_LOST_OE(loe_b));

   eq_bus_host u_host (.clk(mclk), .sda(sda), .scl(scl), .sda_low(host_low));

   // 40 MHz clock
   initial mclk = 1'b0;
   always #12.5 mclk = ~mclk;

   // hang guard: a run past the ceiling counts as a mismatch
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         error_cnt++;
         give_verdict();
      end
   end

   // single place that ends the run
   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // compare one bit
   task automatic check_bit(input string what, input logic exp, input logic got);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %b, seen %b", what, exp, got);
      end
   endtask

   // compare one byte
   task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   // wait for pin changes to pass the synchroniser, then sample off the edge
   task automatic settle();
      repeat (5) @(posedge mclk);
      #1;
   endtask

   // address frame alone; nack is the level seen in the acknowledge slot
   task automatic probe(input logic [6:0] a, input logic nack);
      u_host.start();
      u_host.xfer({a, 1'b0, 1'b1}, rx);
      check_bit("address acknowledge", nack, rx[0]);
      u_host.stop();
   endtask

   // pointer then one data byte
   task automatic reg_write(input logic [1:0] ptr, input logic [7:0] d);
      u_host.start();
      u_host.xfer({7'h2C, 1'b0, 1'b1}, rx);
      u_host.xfer({6'h00, ptr, 1'b1}, rx);
      u_host.xfer({d, 1'b1}, rx);
      check_bit("data acknowledge", 1'b0, rx[0]);
      u_host.stop();
   endtask

   // pointer, repeated start, one byte read and ended by a nack
   task automatic reg_read(input logic [1:0] ptr, input logic [7:0] exp);
      u_host.start();
      u_host.xfer({7'h2C, 1'b0, 1'b1}, rx);
      u_host.xfer({6'h00, ptr, 1'b1}, rx);
      u_host.start();
      u_host.xfer({7'h2C, 1'b1, 1'b1}, rx);
      u_host.xfer({8'hFF, 1'b1}, rx);
      check_byte("register read", exp, rx[8:1]);
      u_host.stop();
   endtask

   // one line as each test ends
   task automatic end_test(input string name);
      $display("test %s done, %0d mismatches so far", name, error_cnt);
   endtask

   // main sequence
   initial begin
      {rst, mode_sel, chip_sel, strap} = 6'h3F;
      {off_a, off_b, below_a, below_b} = 4'h0;
      {error_cnt, n_checks, cycles} = '0;
      @(posedge mclk);
      #1;
      check_bit("enable a in reset", 1'b1, en_a);
      check_bit("data drive in reset", 1'b0, sda_oe);
      @(posedge mclk);
      rst <= 1'b0;
      settle();
      end_test("reset");
      // plain pin cases, squelch off
      foreach (ROWS[i]) begin
         @(posedge mclk);
         {off_a, off_b, below_a, below_b} <= ROWS[i][7:4];
         settle();
         check_bit("enable a", ROWS[i][3], en_a);
         check_bit("enable b", ROWS[i][2], en_b);
         check_bit("lost a", ROWS[i][1], lost_a);
         check_bit("lost b", ROWS[i][0], lost_b);
      end
      end_test("pins");
      // every strap setting, plus a wrong fixed bit and a wrong low bit
      for (int s = 0; s < 8; s++) begin
         @(posedge mclk);
         strap <= 3'(s);
         settle();
         adr = {`ADDR_FIXED_HI, strap[2], ~strap[1:0]};
         probe(adr, 1'b0);
         probe(adr ^ 7'h08, 1'b1);
         probe(adr ^ 7'h01, 1'b1);
      end
      end_test("address");
      // interface gating by chip select and mode select
      @(posedge mclk);
      chip_sel <= 1'b0;
      settle();
      probe(7'h2C, 1'b1);
      chip_sel <= 1'b1;
      mode_sel <= 1'b0;
      settle();
      probe(7'h2C, 1'b1);
      @(posedge mclk);
      mode_sel <= 1'b1;
      settle();
      probe(7'h2C, 1'b0);
      end_test("gating");
      // squelch through the serial setting; status is read-only
      reg_write(2'h0, 8'h03);
      {off_a, off_b, below_a, below_b} <= 4'h2;
      settle();
      check_bit("squelched a", 1'b0, en_a);
      check_bit("unsquelched b", 1'b1, en_b);
      reg_read(2'h0, 8'h03);
      reg_write(2'h1, 8'hFF);
      reg_read(2'h1, 8'h04);
      reg_write(2'h2, 8'h5A);
      reg_read(2'h2, 8'h5A);
      // burst read from the last register: master ack, pointer wraps to control
      reg_write(2'h3, 8'hC3);
      u_host.start();
      u_host.xfer({7'h2C, 1'b0, 1'b1}, rx);
      u_host.xfer({6'h00, 2'h3, 1'b1}, rx);
      u_host.start();
      u_host.xfer({7'h2C, 1'b1, 1'b1}, rx);
      u_host.xfer({8'hFF, 1'b0}, rx);
      check_byte("burst first byte", 8'hC3, rx[8:1]);
      u_host.xfer({8'hFF, 1'b1}, rx);
      check_byte("burst wrapped byte", 8'h03, rx[8:1]);
      u_host.stop();
      // squelch of channel B only trips while B is below threshold
      {off_a, off_b, below_a, below_b} <= 4'h1;
      settle();
      check_bit("squelched b", 1'b0, en_b);
      check_bit("unsquelched a", 1'b1, en_a);
      end_test("squelch");
      // second reset clears the settings
      @(posedge mclk);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      settle();
      check_bit("enable a after reset", 1'b1, en_a);
      check_bit("enable b after reset", 1'b1, en_b);
      reg_read(2'h0, 8'h00);
      reg_read(2'h2, 8'h00);
      end_test("second reset");
      give_verdict();
   end
endmodule
`default_nettype wire
